// ==== design/oms_mode_ctrl.sv ====
/*
 * Operating mode selector: off/reset, manual and automatic, chosen from panel
 * buttons, remote mode contacts and a password protected modbus command.
 * Assumes buttons and contacts are raw pins, modbus writes and settings come
 * from logic on ref_clk_i.
 */
`timescale 1ns/100ps
`include "oms_regs.svh"

module oms_mode_ctrl
  import oms_pkg::*;
#(
  parameter int unsigned HOLD_CYC = 32'(`OMS_BTN_HOLD_CYC),
  parameter int unsigned WIN_CYC = 32'(`OMS_CMD_WIN_CYC)
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // panel buttons and remote contacts, raw pins
  input wire logic btn_stop_i,
  input wire logic btn_auto_i,
  input wire logic btn_start_i,
  input wire logic remote_off_input_function_i,
  input wire logic remote_manual_input_function_i,
  input wire logic remote_automatic_input_function_i,
  // settings
  input wire logic remote_off_cfg_i,
  input wire logic remote_manual_cfg_i,
  input wire logic remote_automatic_cfg_i,
  input wire logic [15:0] cmd_password_cfg_i,
  input wire logic [15:0] log_enable_cfg_i,
  input wire logic [7:0] app_type_i,
  input wire logic protection_trip_i,
  // modbus holding register writes
  input wire logic mb_wr_i,
  input wire logic [15:0] mb_addr_i,
  input wire logic [15:0] mb_wdata_i,
  // mode indication
  output logic off_mode_output_o,
  output logic manual_mode_output_o,
  output logic automatic_mode_output_o,
  output logic not_off_mode_output_o,
  output logic off_status_flag_o,
  output logic manual_status_flag_o,
  output logic automatic_status_flag_o,
  output logic lock_indication_o,
  // engine and load control
  output logic engine_stop_o,
  output logic clear_anomalies_o,
  output logic prog_allowed_o,
  output logic auto_control_o,
  output logic operator_ignored_o,
  output logic generator_breaker_open_o,
  output logic clutch_disengage_o,
  output logic lights_all_off_o,
  // history events
  output logic event_valid_o,
  output logic [15:0] event_code_o
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [15:0] evt_code(input oms_mode_t m);
    logic [15:0] c;
    c = `OMS_EVT_OFF;
    unique case (m)
      OMS_MODE_OFF: c = `OMS_EVT_OFF;
      OMS_MODE_MAN: c = `OMS_EVT_MAN;
      OMS_MODE_AUTO: c = `OMS_EVT_AUTO;
      default: c = `OMS_EVT_OFF;
    endcase
    return c;
  endfunction

  // ****************************************
  // pin synchronisers and filter
  // ****************************************
  logic [5:0] pins;
  logic [5:0] s1_q, s2_q, s3_q, clean_q, clean_d;
  assign pins = {remote_automatic_input_function_i, remote_manual_input_function_i,
                 remote_off_input_function_i, btn_start_i, btn_auto_i, btn_stop_i};

  // a bit moves only once stages two and three agree
  always_comb
  begin
    clean_d = (s2_q & s3_q) | (clean_q & (s2_q | s3_q));
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      s3_q <= 6'h00;
      clean_q <= 6'h00;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end

  logic rem_off, rem_man, rem_auto, rem_any, off_only;
  logic [2:0] btn;
  assign btn = clean_q[2:0];
  assign rem_off = clean_q[3] & remote_off_cfg_i;
  assign rem_man = clean_q[4] & remote_manual_cfg_i;
  assign rem_auto = clean_q[5] & remote_automatic_cfg_i;
  assign rem_any = rem_off | rem_man | rem_auto;
  assign off_only = remote_off_cfg_i & ~remote_manual_cfg_i & ~remote_automatic_cfg_i;

  // ****************************************
  // button hold timer
  // ****************************************
  logic [2:0] btn_prev_q;
  logic [31:0] hold_q, hold_d;
  logic btn_fire;
  // fires once per press; holding longer repeats nothing
  assign btn_fire = $onehot(btn) && (btn == btn_prev_q) && (hold_q == HOLD_CYC - 32'd1);

  always_comb
  begin
    hold_d = hold_q;
    if (!$onehot(btn) || btn != btn_prev_q)
      hold_d = 32'd0;
    else if (hold_q < HOLD_CYC)
      hold_d = hold_q + 32'd1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      btn_prev_q <= 3'b000;
      hold_q <= 32'd0;
    end
    else
    begin
      btn_prev_q <= btn;
      hold_q <= hold_d;
    end
  end

  // ****************************************
  // modbus two-step command
  // ****************************************
  logic arm_q, arm_d;
  logic [31:0] win_q, win_d;
  logic wr_pwd, wr_val, mb_ok;
  oms_mode_t mb_mode;
  assign wr_pwd = mb_wr_i && mb_addr_i == `OMS_REG_CMD_PASSWORD;
  assign wr_val = mb_wr_i && mb_addr_i == `OMS_REG_CMD_VALUE;

  always_comb
  begin
    arm_d = arm_q;
    win_d = win_q;
    mb_ok = 1'b0;
    mb_mode = OMS_MODE_OFF;
    if (wr_pwd)
    begin
      arm_d = (mb_wdata_i == cmd_password_cfg_i);
      win_d = WIN_CYC - 32'd1;
    end
    else if (wr_val)
      arm_d = 1'b0;
    else if (arm_q)
    begin
      arm_d = (win_q != 32'd0);
      win_d = (win_q != 32'd0) ? win_q - 32'd1 : 32'd0;
    end
    // bad value or no fresh password: dropped without trace
    if (wr_val && arm_q && !rem_any)
    begin
      mb_ok = 1'b1;
      if (mb_wdata_i == `OMS_CMD_VAL_OFF)
        mb_mode = OMS_MODE_OFF;
      else if (mb_wdata_i == `OMS_CMD_VAL_MAN)
        mb_mode = OMS_MODE_MAN;
      else if (mb_wdata_i == `OMS_CMD_VAL_AUTO)
        mb_mode = OMS_MODE_AUTO;
      else
        mb_ok = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      arm_q <= 1'b0;
      win_q <= 32'd0;
    end
    else
    begin
      arm_q <= arm_d;
      win_q <= win_d;
    end
  end

  // ****************************************
  // mode selection
  // ****************************************
  oms_mode_t mode_q, mode_d, saved_q, saved_d, req;
  logic rem_off_prev_q, req_ok, log_d;

  always_comb
  begin
    req = mode_q;
    req_ok = 1'b0;
    saved_d = saved_q;
    if (rem_off && !rem_off_prev_q)
      saved_d = mode_q;
    if (rem_off)
    begin
      req = OMS_MODE_OFF;
      req_ok = 1'b1;
    end
    else if (rem_man)
    begin
      req = OMS_MODE_MAN;
      req_ok = 1'b1;
    end
    else if (rem_auto)
    begin
      req = OMS_MODE_AUTO;
      req_ok = 1'b1;
    end
    else if (rem_off_prev_q && off_only)
    begin
      req = saved_q;
      req_ok = 1'b1;
    end
    else if (btn_fire)
    begin
      req_ok = 1'b1;
      unique case (btn)
        3'b001: req = OMS_MODE_OFF;
        3'b010: req = OMS_MODE_AUTO;
        3'b100: req = OMS_MODE_MAN;
        default: req_ok = 1'b0;
      endcase
    end
    else if (mb_ok)
    begin
      req = mb_mode;
      req_ok = 1'b1;
    end
    mode_d = req_ok ? req : mode_q;
    // same mode requested: no change, no event
    log_d = (mode_d != mode_q) && log_enable_cfg_i[`OMS_LOG_MODE_BIT];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      mode_q <= OMS_MODE_OFF;
      saved_q <= OMS_MODE_OFF;
      rem_off_prev_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      saved_q <= saved_d;
      rem_off_prev_q <= rem_off;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  logic is_off, is_man, is_auto, disc_d;
  assign is_off = mode_d == OMS_MODE_OFF;
  assign is_man = mode_d == OMS_MODE_MAN;
  assign is_auto = mode_d == OMS_MODE_AUTO;
  // protections may force loads off in manual and automatic
  assign disc_d = is_off | protection_trip_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      off_mode_output_o <= 1'b1;
      manual_mode_output_o <= 1'b0;
      automatic_mode_output_o <= 1'b0;
      not_off_mode_output_o <= 1'b0;
      off_status_flag_o <= 1'b1;
      manual_status_flag_o <= 1'b0;
      automatic_status_flag_o <= 1'b0;
      lock_indication_o <= 1'b0;
      engine_stop_o <= 1'b1;
      clear_anomalies_o <= 1'b1;
      prog_allowed_o <= 1'b1;
      auto_control_o <= 1'b0;
      operator_ignored_o <= 1'b0;
      generator_breaker_open_o <= 1'b0;
      clutch_disengage_o <= 1'b0;
      lights_all_off_o <= 1'b0;
      event_valid_o <= 1'b0;
      event_code_o <= `OMS_EVT_OFF;
    end
    else
    begin
      off_mode_output_o <= is_off;
      manual_mode_output_o <= is_man;
      automatic_mode_output_o <= is_auto;
      not_off_mode_output_o <= is_man | is_auto;
      off_status_flag_o <= is_off;
      manual_status_flag_o <= is_man;
      automatic_status_flag_o <= is_auto;
      lock_indication_o <= rem_any;
      // trip stops the engine only once loads are already disconnected
      engine_stop_o <= is_off | (protection_trip_i & (generator_breaker_open_o | clutch_disengage_o |
                       lights_all_off_o));
      clear_anomalies_o <= is_off;
      prog_allowed_o <= is_off;
      auto_control_o <= is_auto;
      operator_ignored_o <= is_auto;
      generator_breaker_open_o <= disc_d && app_type_i == `OMS_APP_AUTO_START;
      clutch_disengage_o <= disc_d && app_type_i == `OMS_APP_DRIVE;
      lights_all_off_o <= disc_d && app_type_i == `OMS_APP_LIGHT_TOWER;
      event_valid_o <= log_d;
      event_code_o <= log_d ? evt_code(mode_d) : event_code_o;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_remote_off_force: assert property (rem_off |=> mode_q == OMS_MODE_OFF && off_status_flag_o)
    else $error("remote off did not force off mode");
  a_remote_prio_man: assert property (!rem_off && rem_man |=> mode_q == OMS_MODE_MAN)
    else $error("remote manual priority broken");
  a_remote_lock_btn: assert property (rem_any && btn_fire |=> mode_q == $past(req))
    else $error("button acted under remote lock");
  a_lock_shown: assert property (rem_any |=> lock_indication_o)
    else $error("lock indication missing");
  a_btn_hold_len: assert property (btn_fire |-> $past(btn, 2) == btn && hold_q == HOLD_CYC - 32'd1)
    else $error("button fired before hold time");
  a_mb_bad_value: assert property (wr_val && !rem_any && !btn_fire && !rem_off_prev_q &&
    (mb_wdata_i == 16'h0000 || mb_wdata_i > `OMS_CMD_VAL_AUTO) |=> $stable(mode_q))
    else $error("illegal mode value accepted");
  a_mb_unarmed: assert property (wr_val && !arm_q && !rem_any && !btn_fire && !rem_off_prev_q
    |=> $stable(mode_q))
    else $error("mode write accepted without password");
  a_event_on_change: assert property (event_valid_o |-> $changed(mode_q) &&
    event_code_o == evt_code(mode_q))
    else $error("event without matching mode change");
  a_prog_off_only: assert property (prog_allowed_o |-> mode_q == OMS_MODE_OFF && !auto_control_o)
    else $error("programming allowed outside off mode");
  a_restore_mode: assert property (rem_off_prev_q && !rem_any && off_only |=> mode_q == $past(saved_q))
    else $error("previous mode not restored");

  c_btn_change: cover property (btn_fire && !rem_any ##1 $changed(mode_q));
  c_mb_change: cover property (mb_ok ##1 $changed(mode_q));
  c_remote_restore: cover property (rem_off ##1 !rem_off && off_only);
  c_trip_stop: cover property (protection_trip_i && mode_q == OMS_MODE_MAN ##2 engine_stop_o);

endmodule

// ==== common/oms_regs.svh ====
/*
 * Register offsets, field codes and timing figures of the operating mode selector.
 * Assumes a 100 MHz clock; included by the package users by bare name.
 */
`ifndef OMS_REGS_SVH
`define OMS_REGS_SVH

// ****************************************
// modbus holding registers
// ****************************************
`define OMS_REG_CMD_PASSWORD 16'h0065
`define OMS_REG_CMD_VALUE 16'h0066
`define OMS_CMD_VAL_OFF 16'h0001
`define OMS_CMD_VAL_MAN 16'h0002
`define OMS_CMD_VAL_AUTO 16'h0003

// ****************************************
// event codes and settings fields
// ****************************************
`define OMS_EVT_OFF 16'h03E9
`define OMS_EVT_MAN 16'h03EA
`define OMS_EVT_AUTO 16'h03EB
`define OMS_LOG_MODE_BIT 0
`define OMS_APP_AUTO_START 8'h00
`define OMS_APP_DRIVE 8'h0B
`define OMS_APP_LIGHT_TOWER 8'h0C

// ****************************************
// timing
// ****************************************
`define OMS_CLK_PERIOD_NS 64'd10
`define OMS_BTN_HOLD_MS 64'd500
`define OMS_CMD_WIN_MS 64'd5000
// least time: round up
`define OMS_BTN_HOLD_CYC ((`OMS_BTN_HOLD_MS * 64'd1000000 + `OMS_CLK_PERIOD_NS - 64'd1) / `OMS_CLK_PERIOD_NS)
// longest time: round down
`define OMS_CMD_WIN_CYC ((`OMS_CMD_WIN_MS * 64'd1000000) / `OMS_CLK_PERIOD_NS)

`endif

// ==== common/oms_pkg.sv ====
/*
 * Types of the operating mode selector.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package oms_pkg;

  typedef enum logic [1:0]
  {
    OMS_MODE_OFF = 2'b00,
    OMS_MODE_MAN = 2'b01,
    OMS_MODE_AUTO = 2'b10
  } oms_mode_t;

endpackage

// ==== tb/oms_mb_master.sv ====
/*
 * Modbus master model: writes the mode command holding registers.
 * Assumes the selector samples the strobe on the rising edge of ref_clk_i.
 */
`timescale 1ns/100ps
`include "oms_regs.svh"

module oms_mb_master
(
  // clock
  input wire logic ref_clk_i,
  // holding register writes
  output logic mb_wr_o,
  output logic [15:0] mb_addr_o,
  output logic [15:0] mb_wdata_o
);
  initial
  begin
    mb_wr_o = 1'b0;
    mb_addr_o = 16'h0000;
    mb_wdata_o = 16'h0000;
  end

  // released fields show the inverse, so stale data never looks valid
  task automatic write(input logic [15:0] addr, input logic [15:0] data);
    @(posedge ref_clk_i);
    mb_wr_o <= 1'b1;
    mb_addr_o <= addr;
    mb_wdata_o <= data;
    @(posedge ref_clk_i);
    mb_wr_o <= 1'b0;
    mb_addr_o <= ~addr;
    mb_wdata_o <= ~data;
  endtask

  // gap sets how slowly the value follows the password
  task automatic command(input logic [15:0] pw, input logic [15:0] val, input int gap);
    write(`OMS_REG_CMD_PASSWORD, pw);
    repeat (gap) @(posedge ref_clk_i);
    write(`OMS_REG_CMD_VALUE, val);
  endtask
endmodule

// ==== tb/operating_mode_selector_test.sv ====
/*
 * Self-checking bench of the operating mode selector.
 * Assumes the package, the register header and the modbus master model.
 */
`timescale 1ns/100ps
`include "oms_regs.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module operating_mode_selector_test
  import oms_pkg::*;
;
  localparam int unsigned HOLD = 20;
  localparam int unsigned WIN = 50;
  logic ref_clk_i, reset_i, trip, mb_wr, lk;
  logic [2:0] btn, rem, rcfg;
  logic [15:0] pwd, logen, mb_addr, mb_wdata, code_o;
  logic [7:0] app;
  logic off_o, man_o, auto_o, noff_o, offf_o, manf_o, autof_o, lock_o, es_o, clr_o, prog_o, actl_o, opig_o;
  logic brk_o, clu_o, lit_o, ev_o;
  oms_mode_t m;
  int bad_count, check_count;
  logic [7:0] apps [4] = '{8'h00, 8'h0B, 8'h0C, 8'h5A};
  wire [12:0] obs = {off_o, man_o, auto_o, noff_o, offf_o, manf_o, autof_o, es_o, clr_o, prog_o, actl_o, opig_o, lock_o};

  oms_mb_master mst (.ref_clk_i(ref_clk_i), .mb_wr_o(mb_wr), .mb_addr_o(mb_addr), .mb_wdata_o(mb_wdata));

  oms_mode_ctrl #(.HOLD_CYC(HOLD), .WIN_CYC(WIN)) dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .btn_stop_i(btn[2]), .btn_auto_i(btn[1]), .btn_start_i(btn[0]),
    .remote_off_input_function_i(rem[2]), .remote_manual_input_function_i(rem[1]),
    .remote_automatic_input_function_i(rem[0]), .remote_off_cfg_i(rcfg[2]), .remote_manual_cfg_i(rcfg[1]),
    .remote_automatic_cfg_i(rcfg[0]), .cmd_password_cfg_i(pwd), .log_enable_cfg_i(logen), .app_type_i(app),
    .protection_trip_i(trip), .mb_wr_i(mb_wr), .mb_addr_i(mb_addr), .mb_wdata_i(mb_wdata),
    .off_mode_output_o(off_o), .manual_mode_output_o(man_o), .automatic_mode_output_o(auto_o),
    .not_off_mode_output_o(noff_o), .off_status_flag_o(offf_o), .manual_status_flag_o(manf_o),
    .automatic_status_flag_o(autof_o), .lock_indication_o(lock_o), .engine_stop_o(es_o),
    .clear_anomalies_o(clr_o), .prog_allowed_o(prog_o), .auto_control_o(actl_o), .operator_ignored_o(opig_o),
    .generator_breaker_open_o(brk_o), .clutch_disengage_o(clu_o), .lights_all_off_o(lit_o),
    .event_valid_o(ev_o), .event_code_o(code_o));

  // ****************************************
  // expectations
  // ****************************************
  function automatic logic [2:0] ld();
    logic d;
    d = (m == OMS_MODE_OFF) || trip;
    return {d && app == `OMS_APP_AUTO_START, d && app == `OMS_APP_DRIVE, d && app == `OMS_APP_LIGHT_TOWER};
  endfunction

  function automatic logic [12:0] ind();
    logic o, n, a;
    o = m == OMS_MODE_OFF;
    n = m == OMS_MODE_MAN;
    a = m == OMS_MODE_AUTO;
    return {o, n, a, !o, o, n, a, o || (|ld()), o, o, a, a, lk};
  endfunction

  function automatic logic [15:0] m2v(input oms_mode_t x);
    return (x == OMS_MODE_OFF) ? 16'h0001 : (x == OMS_MODE_MAN) ? 16'h0002 : 16'h0003;
  endfunction

  function automatic oms_mode_t v2m(input logic [15:0] v);
    return (v == 16'h0001) ? OMS_MODE_OFF : (v == 16'h0002) ? OMS_MODE_MAN : OMS_MODE_AUTO;
  endfunction

  function automatic logic [15:0] nx();
    return m2v(m) % 16'h0003 + 16'h0001;
  endfunction

  // ****************************************
  // drivers and checks
  // ****************************************
  task automatic chk_state();
    `CHK("indication", ind(), obs)
    `CHK("loads", ld(), {brk_o, clu_o, lit_o})
  endtask

  task automatic mb_cmd(input logic [15:0] pw, input logic [15:0] v, input int gap, input bit ok);
    oms_mode_t nm;
    logic chg;
    mst.command(pw, v, gap);
    // event pulse stands only in the cycle right after the accepting edge
    #1;
    nm = ok ? v2m(v) : m;
    chg = nm != m;
    `CHK("event", chg && logen[`OMS_LOG_MODE_BIT], ev_o)
    if (chg && logen[`OMS_LOG_MODE_BIT]) `CHK("code", 16'h03E8 + m2v(nm), code_o)
    m = nm;
    chk_state();
  endtask

  task automatic press(input logic [2:0] b, input int n, input oms_mode_t nm);
    @(posedge ref_clk_i);
    btn <= b;
    repeat (n) @(posedge ref_clk_i);
    btn <= 3'b000;
    repeat (12) @(posedge ref_clk_i);
    #1;
    m = nm;
    chk_state();
  endtask

  task automatic remote(input logic [2:0] c, input logic [2:0] r, input oms_mode_t nm);
    @(posedge ref_clk_i);
    rcfg <= c;
    rem <= r;
    repeat (10) @(posedge ref_clk_i);
    #1;
    m = nm;
    lk = |(c & r);
    chk_state();
  endtask

  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, bad_count);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // generous: the whole run needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    $display("CHECK FAILED watchdog expected end seen hang");
    wrap_up();
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    {reset_i, trip, lk, btn, rem, rcfg} = {3'b100, 9'h000};
    bad_count = 0;
    check_count = 0;
    m = OMS_MODE_OFF;
    void'($urandom(32'h262d7dd2));
    pwd = 16'($urandom);
    logen = 16'h0001;
    app = apps[$urandom_range(0, 3)];
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    // load outputs leave their reset value only at the first edge after release
    @(posedge ref_clk_i);
    #1;
    chk_state();
    done("reset");
    for (int i = 0; i < 10; i++)
    begin
      @(posedge ref_clk_i);
      logen <= 16'($urandom);
      mb_cmd(pwd, (i < 3) ? 16'(3 - i) : 16'($urandom_range(1, 3)), 0, 1);
    end
    mb_cmd(pwd, m2v(m), 0, 1);
    done("modbus codes");
    mb_cmd(pwd ^ 16'h8000, nx(), 0, 0);
    mb_cmd(pwd, 16'h0000, 0, 0);
    mb_cmd(pwd, 16'($urandom_range(4, 65535)), 0, 0);
    mb_cmd(pwd, nx(), WIN + 5, 0);
    mb_cmd(pwd, nx(), WIN - 10, 1);
    mst.write(`OMS_REG_CMD_VALUE, nx());
    @(posedge ref_clk_i);
    #1;
    chk_state();
    done("modbus refusals");
    mb_cmd(pwd, 16'h0001, 0, 1);
    press(3'b010, 10, OMS_MODE_OFF);
    press(3'b010, HOLD + 10, OMS_MODE_AUTO);
    press(3'b001, HOLD + 10, OMS_MODE_MAN);
    press(3'b100, HOLD + 10, OMS_MODE_OFF);
    press(3'b011, HOLD + 10, OMS_MODE_OFF);
    done("buttons");
    remote(3'b000, 3'b111, m);
    remote(3'b111, 3'b001, OMS_MODE_AUTO);
    press(3'b100, HOLD + 10, OMS_MODE_AUTO);
    mb_cmd(pwd, 16'h0001, 0, 0);
    remote(3'b111, 3'b011, OMS_MODE_MAN);
    remote(3'b111, 3'b111, OMS_MODE_OFF);
    remote(3'b111, 3'b011, OMS_MODE_MAN);
    remote(3'b111, 3'b001, OMS_MODE_AUTO);
    remote(3'b111, 3'b000, OMS_MODE_AUTO);
    press(3'b001, HOLD + 10, OMS_MODE_MAN);
    mb_cmd(pwd, 16'h0003, 0, 1);
    remote(3'b100, 3'b100, OMS_MODE_OFF);
    remote(3'b100, 3'b000, OMS_MODE_AUTO);
    done("remote contacts");
    for (int i = 1; i <= 3; i++)
    begin
      mb_cmd(pwd, 16'(i), 0, 1);
      for (int j = 0; j < 8; j++)
      begin
        @(posedge ref_clk_i);
        app <= apps[j / 2];
        trip <= j[0];
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk_state();
      end
      @(posedge ref_clk_i);
      trip <= 1'b0;
    end
    done("loads and protection");
    wrap_up();
  end
endmodule
